// ===== core/acs_pkg.sv
// Package for the conversion sequencer with two-wire slave
// Assumes a 100 MHz system clock; shared by all core files
package acs_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam real         CONV_TIME_MS    = 16.6;
  localparam real         POR_TIME_MS     = 0.5;
  localparam real         REF_START_MS    = 12.0;
  localparam int unsigned CONV_CYCLES     = int'(CONV_TIME_MS * 1.0e-3 * CLK_HZ);
  localparam int unsigned POR_CYCLES      = int'(POR_TIME_MS * 1.0e-3 * CLK_HZ);
  localparam int unsigned REF_CYCLES      = int'(REF_START_MS * 1.0e-3 * CLK_HZ);
  localparam int unsigned CNT_W           = 32;

  // ****************************************
  // Bus addresses and data layout
  // ****************************************
  localparam logic [6:0]  ADDR_SEL_LOW    = 7'h14;
  localparam logic [6:0]  ADDR_SEL_HIGH   = 7'h54;
  localparam int unsigned RESULT_W        = 16;
  localparam int unsigned PROG_W          = 4;
  localparam logic [15:0] CODE_MAX        = 16'hffff;
  localparam logic [15:0] CODE_MID        = 16'h8000;
  localparam logic [15:0] CODE_MIN        = 16'h0000;

  // ****************************************
  // Register map (byte offsets)
  // ****************************************
  localparam logic [7:0]  REG_CTRL        = 8'h00;
  localparam logic [7:0]  REG_STATUS      = 8'h04;
  localparam logic [7:0]  REG_RESULT      = 8'h08;
  localparam logic [7:0]  REG_SAMPLE      = 8'h0c;
  localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;

  typedef enum logic [1:0] {
    ACS_CONVERT,
    ACS_POWERDOWN,
    ACS_TRANSFER
  } acs_phase_t;

  typedef struct packed {
    logic       start;
    logic       stop;
    logic       rise;
    logic       fall;
    logic       sda;
  } acs_line_ev_t;

  typedef struct packed {
    logic       ack_win;
    logic       sda_oe;
    logic       transfer_done;
  } acs_slave_out_t;

endpackage

// ===== core/acs_line_sync.sv
// Two-stage synchroniser and event decoder for the serial clock and data
// Assumes both pins are asynchronous to hclk
`timescale 1ns/100ps
`default_nettype none
module acs_line_sync (
  input  wire logic          hclk,
  input  wire logic          hresetn,
  input  wire logic          scl_i,
  input  wire logic          sda_i,
  output acs_pkg::acs_line_ev_t ev
);

  typedef struct packed {
    logic [1:0] scl_m;
    logic [1:0] sda_m;
    logic       scl;
    logic       sda;
  } acs_sync_st_t;

  acs_sync_st_t s_q;
  acs_sync_st_t s_d;

  always_comb begin
    s_d       = s_q;
    s_d.scl_m = {s_q.scl_m[0], scl_i};
    s_d.sda_m = {s_q.sda_m[0], sda_i};
    s_d.scl   = s_q.scl_m[1];
    s_d.sda   = s_q.sda_m[1];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '{scl_m: 2'b11, sda_m: 2'b11, scl: 1'b1, sda: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  // The second stage output and its registered copy feed the edge logic
  assign ev.rise  = s_q.scl_m[1] & ~s_q.scl;
  assign ev.fall  = ~s_q.scl_m[1] & s_q.scl;
  assign ev.start = s_q.scl_m[1] & s_q.scl & s_q.sda & ~s_q.sda_m[1];
  assign ev.stop  = s_q.scl_m[1] & s_q.scl & ~s_q.sda & s_q.sda_m[1];
  assign ev.sda   = s_q.sda_m[1];

endmodule
`default_nettype wire

// ===== core/acs_i2c_slave.sv
// Two-wire slave: address match, ack, 16-bit read out, 4-bit write in
// Assumes events from acs_line_sync on the same clock
`timescale 1ns/100ps
`default_nettype none
module acs_i2c_slave (
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire acs_pkg::acs_line_ev_t ev,
  input  wire logic                  address_select_pin,
  input  wire logic                  result_ready,
  input  wire logic [15:0]           result,
  output logic                       ack_pulse,
  output logic                       prog_valid,
  output logic [3:0]                 prog_word,
  output acs_pkg::acs_slave_out_t    so
);

  typedef enum logic [2:0] {
    SL_IDLE, SL_ADDR, SL_ACK, SL_READ, SL_WRITE, SL_SKIP
  } sl_state_t;

  typedef struct packed {
    sl_state_t   st;
    logic [7:0]  sh;
    logic [4:0]  cnt;
    logic        rd;
    logic        acked;
    logic        oe;
    logic [15:0] out;
    logic        ackp;
    logic        pv;
    logic [3:0]  pw;
    logic        done;
  } sl_st_t;

  sl_st_t s_q;
  sl_st_t s_d;
  logic [6:0] my_addr;

  assign my_addr = address_select_pin ? acs_pkg::ADDR_SEL_HIGH : acs_pkg::ADDR_SEL_LOW;

  always_comb begin
    s_d      = s_q;
    s_d.ackp = 1'b0;
    s_d.pv   = 1'b0;
    s_d.done = 1'b0;
    if (ev.start) begin
      s_d.st  = SL_ADDR;
      s_d.cnt = 5'd0;
      s_d.oe  = 1'b0;
    end else if (ev.stop) begin
      // Cut read keeps the held result; sequencer returns to powered-down
      s_d.st = SL_IDLE;
      s_d.oe = 1'b0;
    end else begin
      case (s_q.st)
        SL_ADDR: begin
          if (ev.rise) begin
            s_d.sh  = {s_q.sh[6:0], ev.sda};
            s_d.cnt = s_q.cnt + 5'd1;
          end
          if (ev.fall && s_q.cnt == 5'd8) begin
            s_d.rd  = s_q.sh[0];
            // Busy converter refuses: line stays released
            s_d.acked = (s_q.sh[7:1] == my_addr) && result_ready;
            s_d.oe    = s_d.acked;
            s_d.st    = (s_q.sh[7:1] == my_addr) ? SL_ACK : SL_SKIP;
            s_d.out   = result;
            if (s_d.acked) begin
              s_d.ackp = 1'b1;
            end
          end
        end
        SL_ACK: begin
          if (ev.fall) begin
            s_d.cnt = 5'd0;
            if (!s_q.acked) begin
              s_d.st = SL_SKIP;
              s_d.oe = 1'b0;
            end else if (s_q.rd) begin
              s_d.st = SL_READ;
              s_d.oe = ~s_q.out[15];
            end else begin
              s_d.st = SL_WRITE;
              s_d.oe = 1'b0;
            end
          end
        end
        SL_READ: begin
          if (ev.fall) begin
            s_d.out = {s_q.out[14:0], 1'b0};
            s_d.cnt = s_q.cnt + 5'd1;
            s_d.oe  = ~s_q.out[14];
            if (s_q.cnt == 5'd7) begin
              s_d.oe = 1'b0; // Master acks on ninth clock
            end
            if (s_q.cnt == 5'd8) begin
              s_d.oe = ~s_q.out[15];
              s_d.out = s_q.out;
            end
            if (s_q.cnt >= 5'd16) begin
              s_d.oe   = 1'b0;
              s_d.st   = SL_SKIP;
              s_d.done = 1'b1;
            end
          end
        end
        SL_WRITE: begin
          if (ev.rise && s_q.cnt < 5'd4) begin
            s_d.pw  = {s_q.pw[2:0], ev.sda};
            s_d.cnt = s_q.cnt + 5'd1;
            if (s_q.cnt == 5'd3) begin
              s_d.pv = 1'b1;
            end
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign ack_pulse        = s_q.ackp;
  assign prog_valid       = s_q.pv;
  assign prog_word        = s_q.pw;
  assign so.sda_oe        = s_q.oe;
  assign so.ack_win       = (s_q.st == SL_ACK);
  assign so.transfer_done = s_q.done;

endmodule
`default_nettype wire

// ===== core/acs_sequencer.sv
// Top: conversion sequencer, power control, result register, AHB-Lite slave
// Assumes scl/sda pins asynchronous; sample value comes from analog front end
//
// Added by the designer: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module acs_sequencer #(
  parameter int unsigned CONV_CYCLES_P = acs_pkg::CONV_CYCLES,
  parameter int unsigned POR_CYCLES_P  = acs_pkg::POR_CYCLES,
  parameter int unsigned REF_CYCLES_P  = acs_pkg::REF_CYCLES
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  input  wire logic        address_select_pin,
  input  wire logic [16:0] sample_in,
  output logic             converter_on,
  output logic             reference_on,
  output logic             reference_ready
);

  // ****************************************
  // Line front end and slave
  // ****************************************
  acs_pkg::acs_line_ev_t   ev;
  acs_pkg::acs_slave_out_t so;
  logic                    ack_pulse;
  logic                    prog_valid;
  logic [3:0]              prog_word;

  typedef struct packed {
    acs_pkg::acs_phase_t ph;
    logic [31:0]         cnt;
    logic [31:0]         por_cnt;
    logic                por;
    logic [31:0]         ref_cnt;
    logic                ref_on;
    logic                ref_rdy;
    logic                conv_on;
    logic                sleep_sel;
    logic                rate_sel;
    logic [15:0]         result;
    logic                first;
    logic [31:0]         conv_count;
    logic                diff_mode;
    logic                sda_oe;
    logic                ap_valid;
    logic                ap_write;
    logic [7:0]          ap_addr;
    logic [31:0]         rdata;
  } acs_state_t;

  acs_state_t s_q;
  acs_state_t s_d;
  logic [15:0] code;
  logic        in_convert;

  acs_line_sync u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .scl_i   (scl_i),
    .sda_i   (sda_i),
    .ev      (ev)
  );

  assign in_convert = (s_q.ph == acs_pkg::ACS_CONVERT) || s_q.por;

  acs_i2c_slave u_slave (
    .hclk               (hclk),
    .hresetn            (hresetn),
    .ev                 (ev),
    .address_select_pin (address_select_pin),
    .result_ready       (!in_convert),
    .result             (s_q.result),
    .ack_pulse          (ack_pulse),
    .prog_valid         (prog_valid),
    .prog_word          (prog_word),
    .so                 (so)
  );

  // ****************************************
  // Output code shaping
  // ****************************************
  // sample_in is signed 17-bit: diff mode full scale is -32768 to +32767 codes
  always_comb begin
    code = acs_pkg::CODE_MIN;
    if (s_q.diff_mode) begin
      if ($signed(sample_in) >= 17'sd32767) begin
        code = acs_pkg::CODE_MAX;
      end else if ($signed(sample_in) <= -17'sd32768) begin
        code = acs_pkg::CODE_MIN;
      end else begin
        code = sample_in[15:0] + acs_pkg::CODE_MID;
      end
    end else begin
      if (sample_in[16]) begin
        code = acs_pkg::CODE_MIN;
      end else if (sample_in > 17'h0_ffff) begin
        code = acs_pkg::CODE_MAX;
      end else begin
        code = sample_in[15:0];
      end
    end
  end

  // ****************************************
  // Sequencer and register file
  // ****************************************
  always_comb begin
    s_d = s_q;
    // Power-on reset interval holds the phase sequencer idle; the reference count still runs
    if (s_q.por) begin
      if (s_q.por_cnt >= POR_CYCLES_P - 1) begin
        s_d.por     = 1'b0;
        s_d.ph      = acs_pkg::ACS_CONVERT;
        s_d.conv_on = 1'b1;
        s_d.cnt     = '0;
      end else begin
        s_d.por_cnt = s_q.por_cnt + 32'd1;
      end
    end else begin
      case (s_q.ph)
        acs_pkg::ACS_CONVERT: begin
          // No abort path: only reset leaves this phase early
          if (s_q.cnt >= CONV_CYCLES_P - 1) begin
            s_d.ph         = acs_pkg::ACS_POWERDOWN;
            s_d.conv_on    = 1'b0;
            s_d.result     = code;
            s_d.conv_count = s_q.conv_count + 32'd1;
            if (s_q.sleep_sel) begin
              s_d.ref_on  = 1'b0;
              s_d.ref_rdy = 1'b0;
            end
          end else begin
            s_d.cnt = s_q.cnt + 32'd1;
          end
        end
        acs_pkg::ACS_POWERDOWN: begin
          if (ack_pulse) begin
            s_d.ph = acs_pkg::ACS_TRANSFER;
            if (!s_q.ref_on) begin
              s_d.ref_on  = 1'b1;
              s_d.ref_cnt = '0;
            end
          end
        end
        acs_pkg::ACS_TRANSFER: begin
          if (prog_valid && prog_word[3] && !prog_word[2]) begin
            s_d.rate_sel  = prog_word[1];
            s_d.sleep_sel = prog_word[0];
          end
          if (so.transfer_done) begin
            s_d.ph      = acs_pkg::ACS_CONVERT;
            s_d.conv_on = 1'b1;
            s_d.cnt     = '0;
            s_d.first   = 1'b0;
          end else if (ev.stop) begin
            s_d.ph = acs_pkg::ACS_POWERDOWN;
          end
        end
        default: s_d.ph = acs_pkg::ACS_CONVERT;
      endcase
    end
    if (s_q.ref_on && !s_q.ref_rdy) begin
      if (s_q.ref_cnt >= REF_CYCLES_P - 1) begin
        s_d.ref_rdy = 1'b1;
      end else begin
        s_d.ref_cnt = s_q.ref_cnt + 32'd1;
      end
    end
    s_d.sda_oe = so.sda_oe;

    // AHB-Lite: capture address phase, act in data phase
    if (s_q.ap_valid && s_q.ap_write && s_q.ap_addr == acs_pkg::REG_CTRL) begin
      s_d.diff_mode = hwdata[0];
    end
    s_d.ap_valid = hsel && hready && htrans[1];
    s_d.ap_write = hwrite;
    s_d.ap_addr  = haddr[7:0];
    s_d.rdata    = '0;
    if (hsel && hready && htrans[1] && !hwrite) begin
      case (haddr[7:0])
        acs_pkg::REG_CTRL:   s_d.rdata = {31'd0, s_q.diff_mode};
        acs_pkg::REG_STATUS: s_d.rdata = {22'd0, s_q.first, s_q.rate_sel, s_q.sleep_sel,
                                          s_q.ref_rdy, s_q.ref_on, s_q.conv_on, s_q.por, 1'b0, s_q.ph};
        acs_pkg::REG_RESULT: s_d.rdata = {16'd0, s_q.result};
        acs_pkg::REG_SAMPLE: s_d.rdata = s_q.conv_count;
        default:             s_d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q       <= '0;
      s_q.por   <= 1'b1;
      s_q.first <= 1'b1;
      s_q.ref_on <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign hrdata          = s_q.rdata;
  assign hreadyout       = 1'b1;
  assign hresp           = 1'b0;
  assign sda_o           = 1'b0;
  assign sda_oe          = s_q.sda_oe;
  assign converter_on    = s_q.conv_on;
  assign reference_on    = s_q.ref_on;
  assign reference_ready = s_q.ref_rdy;

endmodule
`default_nettype wire

// ===== bench/acs_sequencer_assertions.sv
// Checker for the port behaviour of acs_sequencer
// Assumes one hclk domain; bound to the top by the statement at the foot
`timescale 1ns/100ps
`default_nettype none
module acs_sequencer_checker #(
  parameter int unsigned CONV_CYCLES_P = 200,
  parameter int unsigned POR_CYCLES_P  = 10,
  parameter int unsigned REF_CYCLES_P  = 50
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic converter_on,
  input wire logic reference_on,
  input wire logic reference_ready
);
  // ************
  // Helper counters
  // ************
  logic [31:0] conv_q;
  logic [31:0] ref_q;
  logic [31:0] por_q;
  logic        seen_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conv_q <= '0;
      ref_q  <= '0;
      por_q  <= '0;
      seen_q <= 1'b0;
    end else begin
      conv_q <= converter_on ? conv_q + 1 : '0;
      ref_q  <= reference_on ? ref_q + 1 : '0;
      por_q  <= seen_q ? por_q : por_q + 1;
      seen_q <= seen_q | converter_on;
    end
  end
  // ************
  // Properties
  // ************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_drain; sda_oe |-> !sda_o; endproperty
  a_drain: assert property (p_drain) else $error("data line driven high");
  // Sync delay of a few cycles: clock must have been low just before
  property p_fall_edge;
    $changed(sda_oe) |-> !($past(scl_i, 2) && $past(scl_i, 3) && $past(scl_i, 4) && $past(scl_i, 5));
  endproperty
  a_fall_edge: assert property (p_fall_edge) else $error("data changed away from clock fall");
  property p_busy_nak; sda_oe |-> !converter_on; endproperty
  a_busy_nak: assert property (p_busy_nak) else $error("line pulled while converting");
  property p_conv_len;
    $fell(converter_on) |-> conv_q + 2 >= CONV_CYCLES_P && conv_q <= CONV_CYCLES_P + 2;
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");
  property p_por;
    $rose(converter_on) && !seen_q |-> por_q + 1 >= POR_CYCLES_P && por_q <= POR_CYCLES_P + 4;
  endproperty
  a_por: assert property (p_por) else $error("first conversion start misplaced");
  property p_nap_ref;
    $fell(reference_on) |-> $past(converter_on, 1) || $past(converter_on, 2) || $past(converter_on, 3);
  endproperty
  a_nap_ref: assert property (p_nap_ref) else $error("reference dropped outside completion");
  property p_ref_wake;
    $rose(reference_on) |-> sda_oe || $past(sda_oe, 1) || $past(sda_oe, 2) || $past(sda_oe, 3);
  endproperty
  a_ref_wake: assert property (p_ref_wake) else $error("reference woke without ack");
  property p_ref_ready;
    $rose(reference_ready) |-> ref_q + 2 >= REF_CYCLES_P && ref_q <= REF_CYCLES_P + POR_CYCLES_P + 4;
  endproperty
  a_ref_ready: assert property (p_ref_ready) else $error("reference ready time wrong");
  property p_okay; hreadyout && !hresp; endproperty
  a_okay: assert property (p_okay) else $error("bus slave not ready or not okay");
  c_conv: cover property ($fell(converter_on));
  c_sleep: cover property ($fell(reference_on));
  c_wake: cover property ($rose(reference_on));
  c_ack: cover property ($rose(sda_oe));
endmodule

bind acs_sequencer acs_sequencer_checker #(
  .CONV_CYCLES_P(CONV_CYCLES_P), .POR_CYCLES_P(POR_CYCLES_P), .REF_CYCLES_P(REF_CYCLES_P)
) i_chk (
  .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp), .scl_i(scl_i),
  .sda_o(sda_o), .sda_oe(sda_oe), .converter_on(converter_on), .reference_on(reference_on),
  .reference_ready(reference_ready)
);
`default_nettype wire

// ===== bench/acs_bus_master.sv
// Behavioural two-wire bus master, 80 ns serial clock
// Assumes a pull-up on the data line, resolved in the bench
`timescale 1ns/100ps
`default_nettype none
module acs_bus_master (
  output logic      scl,
  output logic      pull_low,
  input  wire logic sda
);
  initial begin
    scl = 1'b1;
    pull_low = 1'b0;
  end
  // Long low phase: the slave's synchronised answer settles before the rise
  task automatic bit_out(input logic b);
    #10 pull_low = !b;
    #40 scl = 1'b1;
    #30 scl = 1'b0;
  endtask
  // Sample late in the high phase: slave data lags the fall by the sync delay
  task automatic bit_in(output logic b);
    #10 pull_low = 1'b0;
    #40 scl = 1'b1;
    #25 b = sda;
    #5 scl = 1'b0;
  endtask
  task automatic frame(input logic [6:0] a, input logic rd, input int nbits, input logic [3:0] word,
                       output logic ack, output logic [15:0] data);
    logic       b;
    logic [7:0] ab;
    ab = {a, rd};
    data = '0;
    // Keep line events off the hclk edges
    #2;
    #40 pull_low = 1'b1;
    #40 scl = 1'b0;
    for (int k = 7; k >= 0; k--) bit_out(ab[k]);
    bit_in(b);
    ack = !b;
    if (ack && rd) begin
      for (int k = 0; k < nbits; k++) begin
        bit_in(b);
        data = {data[14:0], b};
        if (k == 7 || k == 15) bit_out(k == 15 || nbits == 8);
      end
    end
    if (ack && !rd) begin
      for (int k = 3; k >= 0; k--) bit_out(word[k]);
    end
    #20 pull_low = 1'b1;
    #20 scl = 1'b1;
    #40 pull_low = 1'b0;
    #40;
  endtask
endmodule
`default_nettype wire

// ===== bench/tb.sv
// Self-checking bench for acs_sequencer with a bus master model
// Assumes shortened conversion, reset and reference counts
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, hready;
  logic        address_select_pin, scl, m_low, sda_o, sda_oe, ack;
  logic        converter_on, reference_on, reference_ready, diff_q, sleep_q;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [16:0] sample_in, s;
  logic [15:0] data, exp;
  logic [6:0]  me;
  int          num_errors, num_checks, conv_count, cycles;
  integer      seed = 32'h3639_a017;
  logic [16:0] dtab [3] = '{17'h1_0000, 17'h0_0000, 17'h0_ffff};
  logic [3:0]  wtab [6] = '{4'h1, 4'hd, 4'h9, 4'h4, 4'h8, 4'ha};
  wire         sda_line = !(m_low || (sda_oe && !sda_o));
  assign hready = hreadyout;
  acs_sequencer #(.CONV_CYCLES_P(200), .POR_CYCLES_P(10), .REF_CYCLES_P(50)) i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
    .address_select_pin(address_select_pin), .sample_in(sample_in), .converter_on(converter_on),
    .reference_on(reference_on), .reference_ready(reference_ready));
  acs_bus_master i_master (.scl(scl), .pull_low(m_low), .sda(sda_line));
  always #5 hclk = ~hclk;
  // ************
  // Shared tasks
  // ************
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    num_checks++;
    if (seen !== want) begin
      num_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] r);
    @(posedge hclk);
    {hsel, htrans, haddr, hwrite} <= {1'b1, 2'b10, a, w};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    {hsel, htrans, hwdata} <= {1'b0, 2'b00, wd};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  function automatic logic [15:0] code_of(input logic [16:0] v, input logic d);
    int c;
    c = $signed(v) + (d ? 32768 : 0);
    if (c < 0) c = 0;
    if (c > 65535) c = 65535;
    return c[15:0];
  endfunction
  task automatic wait_conv();
    int n;
    n = 0;
    while (converter_on !== 1'b1 && n < 1000) begin @(posedge hclk); n++; end
    while (converter_on !== 1'b0 && n < 1000) begin @(posedge hclk); n++; end
    chk(32'(n < 1000), 1);
    conv_count++;
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end
  // ************
  // Main sequence
  // ************
  initial begin
    {hclk, hresetn, hsel, htrans, hwrite, haddr, hwdata, hsize} = {6'h00, 64'h0, 3'h2};
    {address_select_pin, diff_q, sleep_q} = 3'b000;
    sample_in = 17'($random(seed));
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, 32'h0000_0000, 32'h0, rd);
    chk(rd, 32'h0000_0000);
    wait_conv();
    i_master.frame(acs_pkg::ADDR_SEL_LOW, 1'b1, 16, 4'h0, ack, data); // data ignored
    chk(32'(ack), 1);
    chk(32'(converter_on), 1);
    i_master.frame(acs_pkg::ADDR_SEL_LOW, 1'b1, 16, 4'h0, ack, data);
    chk(32'(ack), 0);
    for (int i = 0; i < 6; i++) begin
      s = 17'($random(seed));
      if (i == 1) s[16] = 1'b1;
      if (i == 2) s = {1'b0, s[15:8], 1'b1, s[6:0]}; // Bit 7 high keeps the line free for the stop
      if (i >= 3) s = dtab[i-3];
      if (i == 3) begin
        ahb(1'b1, 32'h0000_0000, 32'h0000_0001, rd);
        ahb(1'b0, 32'h0000_0000, 32'h0, rd);
        chk(rd, 32'h0000_0001);
        diff_q = 1'b1;
      end
      me = (i >= 4) ? acs_pkg::ADDR_SEL_HIGH : acs_pkg::ADDR_SEL_LOW;
      @(posedge hclk);
      address_select_pin <= (i >= 4);
      sample_in <= s;
      exp = code_of(s, diff_q);
      wait_conv();
      @(posedge hclk);
      sample_in <= ~s;
      i_master.frame(me ^ 7'h40, 1'b1, 16, 4'h0, ack, data);
      chk(32'(ack), 0);
      chk(32'(reference_on), 32'(!sleep_q));
      ahb(1'b0, 32'h0000_0008, 32'h0, rd);
      chk(rd, 32'(exp));
      if (i == 2) begin
        i_master.frame(me, 1'b1, 8, 4'h0, ack, data);
        chk(32'(data), 32'(exp[15:8]));
      end
      i_master.frame(me, 1'b0, 0, wtab[i], ack, data);
      chk(32'(ack), 1);
      chk(32'(reference_on), 1);
      if (wtab[i][3:2] == 2'b10) sleep_q = wtab[i][0];
      i_master.frame(me, 1'b1, 16, 4'h0, ack, data);
      chk(32'(data), 32'(exp));
      chk(32'(converter_on), 1);
    end
    wait_conv();
    ahb(1'b0, 32'h0000_000c, 32'h0, rd);
    chk(rd, 32'(conv_count));
    ahb(1'b1, 32'h0000_0010, 32'hffff_ffff, rd);
    ahb(1'b0, 32'h0000_0010, 32'h0, rd);
    chk(rd, 32'h0000_0000);
    report_and_stop();
  end
endmodule
`default_nettype wire
